// file: design/hpc_config.sv
// hot-plug signal configuration register and pin polarity logic
`timescale 1ns/100ps
module hpc_config #(
	parameter logic [21:0] PULSE_CYC = 22'(hpc_pkg::HPC_PULSE_CYC)
) (
	// clock and resets
	input  wire logic                              clk,
	input  wire logic                              rst_b,
	input  wire logic                              hot_rst,
	// configuration access
	input  wire logic                              cfg_wr,
	input  wire logic                              cfg_rd,
	input  wire logic [hpc_pkg::HPC_ADDR_W-1:0]    cfg_addr,
	input  wire logic [3:0]                        cfg_be,
	input  wire logic [31:0]                       cfg_wdata,
	output logic      [31:0]                       cfg_rdata_r,
	output logic                                   cfg_rvalid_r,
	// slot capability and core requests
	input  wire logic [hpc_pkg::HPC_PORTS-1:0]     latch_present_cap,
	input  wire hpc_pkg::hpc_req_t                 req,
	// slot pins
	input  wire hpc_pkg::hpc_pin_in_t              pins,
	output logic      [hpc_pkg::HPC_PORTS-1:0]     attn_indicator_out,
	output logic      [hpc_pkg::HPC_PORTS-1:0]     power_indicator_out,
	output logic      [hpc_pkg::HPC_PORTS-1:0]     power_enable_out,
	output logic      [hpc_pkg::HPC_PORTS-1:0]     interlock_out,
	// sensed state to the core
	output hpc_pkg::hpc_sense_t                    sense_r
);
	import hpc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	hpc_ctl_t               ctl_r;
	hpc_ctl_t               ctl_nxt;
	logic [31:0]            rdata_nxt;
	logic                   rvalid_nxt;
	logic                   hit;
	hpc_sense_t             sense_nxt;
	logic [HPC_PORTS-1:0]   latch_c;
	logic [HPC_PORTS-1:0]   latch_open_c;
	logic [HPC_PORTS-1:0]   pwr_norm_c;
	logic [HPC_PORTS-1:0]   ilock_lvl;
	logic [HPC_PORTS-1:0]   ai_nxt;
	logic [HPC_PORTS-1:0]   pi_nxt;
	logic [HPC_PORTS-1:0]   pe_nxt;
	logic [HPC_PORTS-1:0]   il_nxt;

	assign hit = (cfg_addr == HPC_CFG_OFF);

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	// bits 31:14 are not held here and read as zero
	always_comb begin
		ctl_nxt    = ctl_r;
		rvalid_nxt = cfg_rd;
		rdata_nxt  = '0;
		if (cfg_rd && hit) begin
			rdata_nxt = {18'h0, ctl_r};
		end
		if (cfg_wr && hit && cfg_be[0]) begin
			ctl_nxt[HPC_BYTE0_MSB:0] = cfg_wdata[HPC_BYTE0_MSB:0];
		end
		if (cfg_wr && hit && cfg_be[1]) begin
			ctl_nxt[HPC_CTL_W-1:HPC_BYTE1_LSB] =
				cfg_wdata[HPC_CTL_W-1:HPC_BYTE1_LSB];
		end
		// hot reset only returns the non-sticky bits to reset value
		if (hot_rst) begin
			ctl_nxt = (ctl_nxt & HPC_STICKY_MSK)
				| (HPC_CTL_RST & ~HPC_STICKY_MSK);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_r        <= HPC_CTL_RST;
			cfg_rdata_r  <= '0;
			cfg_rvalid_r <= 1'b0;
		end else begin
			ctl_r        <= ctl_nxt;
			cfg_rdata_r  <= rdata_nxt;
			cfg_rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// input polarity and latch handling
	// ----------------------------------------------------------------
	assign latch_c = pins.latch_sensor_in
		^ hpc_rep(ctl_r.invert_latch_sensor);
	// no latch status is reported while the input serves the interlock
	assign latch_open_c = ctl_r.latch_input_as_interlock_state
		? '0 : latch_c;

	always_comb begin
		sense_nxt.attn_button = pins.attn_button_in
			^ hpc_rep(ctl_r.invert_attn_button);
		sense_nxt.presence = pins.presence_detect_in
			^ hpc_rep(ctl_r.invert_presence_detect);
		sense_nxt.power_fault = pins.power_fault_in
			^ hpc_rep(ctl_r.invert_power_fault);
		sense_nxt.latch_open = latch_open_c;
		sense_nxt.interlock_state = ctl_r.latch_input_as_interlock_state
			? latch_c : '0;
		sense_nxt.power_good = pins.power_good_in
			^ hpc_rep(ctl_r.invert_power_good);
		ai_nxt = req.attn_ind_on
			^ hpc_rep(ctl_r.invert_attn_indicator);
		pi_nxt = req.power_ind_on
			^ hpc_rep(ctl_r.invert_power_indicator);
		pe_nxt = pwr_norm_c
			^ hpc_rep(ctl_r.invert_power_enable);
		il_nxt = ilock_lvl
			^ hpc_rep(ctl_r.invert_interlock_out);
	end

	// ----------------------------------------------------------------
	// interlock drivers, one per port
	// ----------------------------------------------------------------
	for (genvar i = 0; i < HPC_PORTS; i++) begin : g_il
		hpc_interlock #(
			.PULSE_CYC   (PULSE_CYC)
		) u_il (
			.clk         (clk),
			.rst_b       (rst_b),
			.toggle_mode (ctl_r.interlock_toggle_mode),
			.ctl_wr      (req.interlock_wr[i]),
			.level_r     (ilock_lvl[i])
		);
	end

	// ----------------------------------------------------------------
	// output polarity
	// ----------------------------------------------------------------
	// open latch overrides the core's power request without delay
	assign pwr_norm_c = req.power_on & ~(hpc_rep(
		ctl_r.latch_open_auto_power_off) & latch_present_cap
		& latch_open_c);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sense_r             <= '0;
			attn_indicator_out  <= '0;
			power_indicator_out <= '0;
			power_enable_out    <= '0;
			interlock_out       <= '0;
		end else begin
			sense_r             <= sense_nxt;
			attn_indicator_out  <= ai_nxt;
			power_indicator_out <= pi_nxt;
			power_enable_out    <= pe_nxt;
			interlock_out       <= il_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_attn_in;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> sense_r.attn_button == ($past(pins.attn_button_in)
			^ {HPC_PORTS{$past(ctl_r.invert_attn_button)}});
	endproperty
	a_attn_in: assert property (p_attn_in)
		else $error("attention button polarity wrong");

	property p_presence_in;
		@(posedge clk) disable iff (!rst_b)
		ctl_r.invert_presence_detect ##1 ctl_r.invert_presence_detect
			|-> sense_r.presence == ~$past(pins.presence_detect_in);
	endproperty
	a_presence_in: assert property (p_presence_in)
		else $error("presence detect not inverted");

	property p_fault_in;
		@(posedge clk) disable iff (!rst_b)
		!ctl_r.invert_power_fault
			|=> sense_r.power_fault == $past(pins.power_fault_in);
	endproperty
	a_fault_in: assert property (p_fault_in)
		else $error("power fault altered while not inverted");

	property p_latch_in;
		@(posedge clk) disable iff (!rst_b)
		(ctl_r.invert_latch_sensor && !ctl_r.latch_input_as_interlock_state)
			|=> sense_r.latch_open == ~$past(pins.latch_sensor_in);
	endproperty
	a_latch_in: assert property (p_latch_in)
		else $error("latch sensor not inverted");

	property p_ai_out;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> attn_indicator_out == ($past(req.attn_ind_on)
			^ {HPC_PORTS{$past(ctl_r.invert_attn_indicator)}});
	endproperty
	a_ai_out: assert property (p_ai_out)
		else $error("attention indicator polarity wrong");

	property p_pi_out;
		@(posedge clk) disable iff (!rst_b)
		ctl_r.invert_power_indicator
			|=> power_indicator_out == ~$past(req.power_ind_on);
	endproperty
	a_pi_out: assert property (p_pi_out)
		else $error("power indicator not inverted");

	property p_auto_off;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> power_enable_out == (($past(req.power_on)
			& ~({HPC_PORTS{$past(ctl_r.latch_open_auto_power_off)}}
			& $past(latch_present_cap) & $past(latch_open_c)))
			^ {HPC_PORTS{$past(ctl_r.invert_power_enable)}});
	endproperty
	a_auto_off: assert property (p_auto_off)
		else $error("power enable not forced off by open latch");

	property p_il_out;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> interlock_out == ($past(ilock_lvl)
			^ {HPC_PORTS{$past(ctl_r.invert_interlock_out)}});
	endproperty
	a_il_out: assert property (p_il_out)
		else $error("interlock output polarity wrong");

	property p_pg_in;
		@(posedge clk) disable iff (!rst_b)
		ctl_r.invert_power_good
			|=> sense_r.power_good == ~$past(pins.power_good_in);
	endproperty
	a_pg_in: assert property (p_pg_in)
		else $error("power good not inverted");

	property p_toggle;
		@(posedge clk) disable iff (!rst_b)
		(ctl_r.interlock_toggle_mode && req.interlock_wr[0]
			&& g_il[0].u_il.state_r == HPC_IL_IDLE)
			|=> ilock_lvl[0] != $past(ilock_lvl[0]);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("interlock did not toggle on write");

	property p_sticky;
		@(posedge clk) disable iff (!rst_b)
		(hot_rst && !cfg_wr) |=> (ctl_r & HPC_STICKY_MSK)
			== ($past(ctl_r) & HPC_STICKY_MSK) && ctl_r.reserved == 2'h0;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("hot reset changed a sticky field");

	property p_pe_out;
		@(posedge clk) disable iff (!rst_b)
		(ctl_r.invert_power_enable && !ctl_r.latch_open_auto_power_off)
			|=> power_enable_out == ~$past(req.power_on);
	endproperty
	a_pe_out: assert property (p_pe_out)
		else $error("power enable not inverted");

	property p_reserved;
		@(posedge clk) disable iff (!rst_b)
		(cfg_wr && hit && cfg_be[1] && !hot_rst)
			|=> ctl_r.reserved == $past(cfg_wdata[10:9]);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits not written");

	property p_latch_swap;
		@(posedge clk) disable iff (!rst_b)
		ctl_r.latch_input_as_interlock_state
			|=> sense_r.latch_open == '0
			&& sense_r.interlock_state == ($past(pins.latch_sensor_in)
			^ {HPC_PORTS{$past(ctl_r.invert_latch_sensor)}});
	endproperty
	a_latch_swap: assert property (p_latch_swap)
		else $error("latch input not used as interlock state");

	property p_rd_answer;
		@(posedge clk) disable iff (!rst_b)
		(cfg_rd && hit) |=> cfg_rvalid_r
			&& cfg_rdata_r == {18'h0, $past(ctl_r)};
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer wrong");

	c_auto_off: cover property (@(posedge clk) disable iff (!rst_b)
		|(req.power_on & latch_present_cap & latch_open_c));
	c_pulse: cover property (@(posedge clk) disable iff (!rst_b)
		req.interlock_wr[0] && !ctl_r.interlock_toggle_mode);
	c_hot: cover property (@(posedge clk) disable iff (!rst_b)
		hot_rst && ctl_r.reserved != 2'h0);
	c_toggle: cover property (@(posedge clk) disable iff (!rst_b)
		req.interlock_wr[0] && ctl_r.interlock_toggle_mode);

endmodule : hpc_config

// file: design/hpc_interlock.sv
// one port's interlock driver: timed pulse or toggle
`timescale 1ns/100ps
module hpc_interlock #(
	parameter logic [21:0] PULSE_CYC = 22'(hpc_pkg::HPC_PULSE_CYC)
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// control
	input  wire logic toggle_mode,
	input  wire logic ctl_wr,
	// state
	output logic      level_r
);
	import hpc_pkg::*;

	hpc_il_state_t          state_r;
	hpc_il_state_t          state_nxt;
	logic [HPC_CNT_W-1:0]   cnt_r;
	logic [HPC_CNT_W-1:0]   cnt_nxt;
	logic                   level_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		level_nxt = level_r;
		case (state_r)
			HPC_IL_IDLE: begin
				if (ctl_wr && toggle_mode) begin
					level_nxt = ~level_r;
				end else if (ctl_wr) begin
					level_nxt = 1'b1;
					cnt_nxt   = PULSE_CYC - 22'd1;
					state_nxt = HPC_IL_PULSE;
				end
			end
			HPC_IL_PULSE: begin
				// a new write restarts the full pulse unless toggle mode is set
				if (ctl_wr && !toggle_mode) begin
					cnt_nxt = PULSE_CYC - 22'd1;
				end else if (cnt_r == '0) begin
					level_nxt = 1'b0;
					state_nxt = HPC_IL_IDLE;
				end else begin
					cnt_nxt = cnt_r - 22'd1;
				end
			end
			default: begin
				state_nxt = HPC_IL_IDLE;
				level_nxt = 1'b0;
				cnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= HPC_IL_IDLE;
			cnt_r   <= '0;
			level_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_pulse_end;
		@(posedge clk) disable iff (!rst_b)
		(state_r == HPC_IL_PULSE && cnt_r == '0 && !ctl_wr)
			|=> !level_r && state_r == HPC_IL_IDLE;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("interlock pulse did not end at count zero");

	property p_pulse_start;
		@(posedge clk) disable iff (!rst_b)
		(state_r == HPC_IL_IDLE && ctl_wr && !toggle_mode)
			|=> level_r && cnt_r == PULSE_CYC - 22'd1;
	endproperty
	a_pulse_start: assert property (p_pulse_start)
		else $error("interlock pulse did not start with full count");

endmodule : hpc_interlock

// file: design/hpc_pkg.sv
// package: hot-plug signal configuration constants and carriers
package hpc_pkg;

	// ----------------------------------------------------------------
	// sizes and register map
	// ----------------------------------------------------------------
	localparam int          HPC_PORTS      = 8;
	localparam int          HPC_ADDR_W     = 12;
	localparam int          HPC_CTL_W      = 14;
	localparam logic [11:0] HPC_CFG_OFF    = 12'h408;
	localparam logic [13:0] HPC_CTL_RST    = 14'h0800;
	// reserved bits 10:9 are not sticky
	localparam logic [13:0] HPC_STICKY_MSK = 14'h39ff;
	localparam int          HPC_BYTE0_MSB  = 7;
	localparam int          HPC_BYTE1_LSB  = 8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint HPC_CLK_HZ       = 25_000_000;
	localparam longint HPC_PULSE_MS     = 125;
	localparam longint HPC_PULSE_CYC    = HPC_PULSE_MS * HPC_CLK_HZ / 1000;
	localparam int     HPC_CNT_W        = 22;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       interlock_toggle_mode;
		logic       latch_input_as_interlock_state;
		logic       latch_open_auto_power_off;
		logic [1:0] reserved;
		logic       invert_power_good;
		logic       invert_interlock_out;
		logic       invert_power_enable;
		logic       invert_power_indicator;
		logic       invert_attn_indicator;
		logic       invert_latch_sensor;
		logic       invert_power_fault;
		logic       invert_presence_detect;
		logic       invert_attn_button;
	} hpc_ctl_t;

	typedef struct packed {
		logic [HPC_PORTS-1:0] attn_button_in;
		logic [HPC_PORTS-1:0] presence_detect_in;
		logic [HPC_PORTS-1:0] power_fault_in;
		logic [HPC_PORTS-1:0] latch_sensor_in;
		logic [HPC_PORTS-1:0] power_good_in;
	} hpc_pin_in_t;

	typedef struct packed {
		logic [HPC_PORTS-1:0] attn_ind_on;
		logic [HPC_PORTS-1:0] power_ind_on;
		logic [HPC_PORTS-1:0] power_on;
		logic [HPC_PORTS-1:0] interlock_wr;
	} hpc_req_t;

	typedef struct packed {
		logic [HPC_PORTS-1:0] attn_button;
		logic [HPC_PORTS-1:0] presence;
		logic [HPC_PORTS-1:0] power_fault;
		logic [HPC_PORTS-1:0] latch_open;
		logic [HPC_PORTS-1:0] interlock_state;
		logic [HPC_PORTS-1:0] power_good;
	} hpc_sense_t;

	typedef enum logic [1:0] {
		HPC_IL_IDLE  = 2'h0,
		HPC_IL_PULSE = 2'h1
	} hpc_il_state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [HPC_PORTS-1:0] hpc_rep(input logic b);
		hpc_rep = {HPC_PORTS{b}};
	endfunction : hpc_rep

endpackage : hpc_pkg

// file: testbench/hpc_slot_model.sv
// slot side model: raw slot pin levels and an interlock pulse gauge
`timescale 1ns/100ps
module hpc_slot_model (
	// clock
	input  wire logic                         clk,
	// levels the slot hardware presents
	input  wire hpc_pkg::hpc_pin_in_t         env,
	// device pins
	output hpc_pkg::hpc_pin_in_t              pins,
	input  wire logic [hpc_pkg::HPC_PORTS-1:0] interlock_out,
	// gauge of port 0 interlock pulse length
	output logic [15:0]                       il_len
);
	import hpc_pkg::*;

	logic        il_prev = 1'b0;
	logic [15:0] len_r   = 16'h0;

	// ----------------------------------------------------------------
	// pins and gauge
	// ----------------------------------------------------------------
	// buttons and sensors are plain levels, no bounce modelled
	assign pins   = env;
	assign il_len = len_r;

	// counts high cycles from each rising edge, restarts on a new pulse
	always @(posedge clk) begin
		if (interlock_out[0] && !il_prev) begin
			len_r <= 16'h1;
		end else if (interlock_out[0]) begin
			len_r <= len_r + 16'h1;
		end
		il_prev <= interlock_out[0];
	end
endmodule : hpc_slot_model

// file: testbench/tb_hotplug_signal_config.sv
// testbench for the hot-plug signal configuration register
`timescale 1ns/100ps
module tb_hotplug_signal_config;
	import hpc_pkg::*;
	localparam logic [21:0] PCYC = 22'h8;
	logic                 clk, rst_b, hot_rst, cfg_wr, cfg_rd, cfg_rvalid_r;
	logic [11:0]          cfg_addr;
	logic [3:0]           cfg_be;
	logic [31:0]          cfg_wdata, cfg_rdata_r;
	logic [HPC_PORTS-1:0] cap, ai, pi, pe, il, lo;
	hpc_req_t             req;
	hpc_pin_in_t          env, pins;
	hpc_sense_t           sense_r;
	logic [15:0]          il_len;
	int                   n_errors, compares, cyc;
	logic [13:0]          rows [16] = '{14'h0000, 14'h0001, 14'h0002,
		14'h0004, 14'h0008, 14'h0010, 14'h0020, 14'h0040, 14'h0080,
		14'h0100, 14'h0600, 14'h0808, 14'h1800, 14'h1000, 14'h3fff,
		14'h0800};

	hpc_config #(.PULSE_CYC(PCYC)) hpc_config_i (.clk(clk), .rst_b(rst_b),
		.hot_rst(hot_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r),
		.latch_present_cap(cap), .req(req), .pins(pins),
		.attn_indicator_out(ai), .power_indicator_out(pi),
		.power_enable_out(pe), .interlock_out(il), .sense_r(sense_r));

	hpc_slot_model hpc_slot_model_i (.clk(clk), .env(env), .pins(pins),
		.interlock_out(il), .il_len(il_len));

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_pins(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk_pins

	task automatic cfg_write(input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk);
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask : cfg_write

	// answer stands one cycle, so it is looked at the next falling edge
	task automatic cfg_read(input logic [11:0] a, input logic [31:0] e);
		@(negedge clk);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk_word("rvalid", 32'h1, {31'h0, cfg_rvalid_r});
		chk_word("rdata", e, cfg_rdata_r);
	endtask : cfg_read

	task automatic pulse_il(input logic [7:0] m);
		@(negedge clk);
		req.interlock_wr = m;
		@(negedge clk);
		req.interlock_wr = 8'h0;
	endtask : pulse_il

	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	// expected levels worked out from the control word with env, req and cap
	task automatic check_all(input logic [13:0] c);
		lo = env.latch_sensor_in ^ {8{c[3]}};
		chk_pins("attn", env.attn_button_in ^ {8{c[0]}},
			sense_r.attn_button);
		chk_pins("pres", env.presence_detect_in ^ {8{c[1]}},
			sense_r.presence);
		chk_pins("fault", env.power_fault_in ^ {8{c[2]}},
			sense_r.power_fault);
		chk_pins("latch", c[12] ? 8'h0 : lo, sense_r.latch_open);
		chk_pins("ilst", c[12] ? lo : 8'h0,
			sense_r.interlock_state);
		chk_pins("pgood", env.power_good_in ^ {8{c[8]}},
			sense_r.power_good);
		chk_pins("aind", req.attn_ind_on ^ {8{c[4]}}, ai);
		chk_pins("pind", req.power_ind_on ^ {8{c[5]}}, pi);
		chk_pins("pwen", (req.power_on
			& ~({8{c[11]}} & cap & (c[12] ? 8'h0 : lo))) ^ {8{c[6]}}, pe);
		chk_pins("ilout", {8{c[7]}}, il);
	endtask : check_all

	// ----------------------------------------------------------------
	// timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{hot_rst, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
		n_errors = 0;
		compares = 0;
		cap = 8'hf0;
		req = '{attn_ind_on: 8'h81, power_ind_on: 8'h42, power_on: 8'hff,
			interlock_wr: 8'h0};
		env = '{attn_button_in: 8'h0f, presence_detect_in: 8'h33,
			power_fault_in: 8'h55, latch_sensor_in: 8'h3c,
			power_good_in: 8'hc3};
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		cfg_read(12'h408, 32'h0800);
		for (int i = 0; i < 16; i++) begin
			cfg_write(12'h408, 4'h3, {18'h0, rows[i]});
			repeat (2) @(negedge clk);
			cfg_read(12'h408, {18'h0, rows[i]});
			check_all(rows[i]);
		end
		// pulse mode: high for exactly the programmed count
		pulse_il(8'h01);
		chk_pins("ilout", 8'h00, il);
		@(negedge clk);
		chk_pins("ilout", 8'h01, il);
		repeat (12) @(negedge clk);
		chk_word("illen", {10'h0, PCYC}, {16'h0, il_len});
		chk_pins("ilout", 8'h00, il);
		// a second write in mid-pulse restarts the full count
		pulse_il(8'h01);
		repeat (3) @(negedge clk);
		pulse_il(8'h01);
		repeat (14) @(negedge clk);
		chk_word("illen", {10'h0, PCYC + 22'h5}, {16'h0, il_len});
		chk_pins("ilout", 8'h00, il);
		// toggle mode: two writes three cycles apart each flip the level
		cfg_write(12'h408, 4'h3, 32'h2800);
		pulse_il(8'h03);
		@(negedge clk);
		chk_pins("ilout", 8'h03, il);
		pulse_il(8'h03);
		@(negedge clk);
		chk_pins("ilout", 8'h00, il);
		// hot reset keeps sticky bits, clears reserved ones
		cfg_write(12'h408, 4'h3, 32'hffff_ffff);
		cfg_read(12'h408, 32'h3fff);
		@(negedge clk);
		hot_rst = 1'b1;
		@(negedge clk);
		hot_rst = 1'b0;
		cfg_read(12'h408, 32'h39ff);
		// low byte only, then a write and read off the map
		cfg_write(12'h408, 4'h1, 32'h0);
		cfg_write(12'h40c, 4'h3, 32'h0);
		cfg_read(12'h408, 32'h3900);
		cfg_read(12'h40c, 32'h0);
		// second power-on reset in mid-run
		@(negedge clk);
		rst_b = 1'b0;
		@(negedge clk);
		rst_b = 1'b1;
		cfg_read(12'h408, 32'h0800);
		wrap_up();
	end
endmodule : tb_hotplug_signal_config
